// ### verilog/subclock_watchdog_cfg.svh
// Purpose: Offsets, field positions, reset values and timing figures of the watchdog.
// Assumes: APB byte addressing with one 32-bit word per register.
// Notes:   Definitions only.
`ifndef SUBCLOCK_WATCHDOG_CFG_SVH
`define SUBCLOCK_WATCHDOG_CFG_SVH

`define WDT_ADDR_WIDTH        16
`define WDT_CTRL_OFFSET       16'hff40
`define WDT_STATUS_OFFSET     16'hff44
`define WDT_ENABLE_POS        7
`define WDT_RESTART_POS       2
`define WDT_ENABLE_RESET      1'h1
`define WDT_STAT_PENDING_POS  0
`define WDT_STAT_STAGE_LSB    4
`define WDT_DEFAULT_PERIOD    131072
`define WDT_STAGE_LAST        2'h3
`define WDT_NMI_LEVEL         3'h4
`define WDT_NMI_VECTOR        24'h000004

`endif

// ### verilog/subclock_watchdog_pkg.sv
// Purpose: Types used by the watchdog design only.
// Assumes: Nothing beyond the configuration header.
// Notes:   Fields of the control word travel together as one struct.
package subclock_watchdog_pkg;

	// Software-visible control state of the watchdog.
	typedef struct packed {
		logic enable;
	} wdt_ctrl_type;

	// Counting state of the timeout stage.
	typedef enum logic [1:0] {
		ST_STOPPED  = 2'b00,
		ST_COUNTING = 2'b01,
		ST_EXPIRED  = 2'b10
	} wdt_state_type;

endpackage : subclock_watchdog_pkg

// ### verilog/subclock_watchdog_timer.sv
// Purpose: Watchdog timer counting sub-clock cycles, raising a non-maskable request.
// Assumes: sub_clock_oscillator is an asynchronous pin, far slower than pclk.
// Notes:   APB slave; pready is always high; unmapped addresses answer pslverr.
`timescale 1ns/1ps
`include "subclock_watchdog_cfg.svh"

module subclock_watchdog_timer #(
	parameter int PERIOD_CYCLES = `WDT_DEFAULT_PERIOD
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [`WDT_ADDR_WIDTH-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        sub_clock_oscillator,
	input  wire logic                        sleep_active,
	output logic                             nmi_request,
	output logic      [2:0]                  nmi_level,
	output logic      [23:0]                 nmi_vector
);

	localparam int QUARTER   = PERIOD_CYCLES / 4;
	localparam int PRE_WIDTH = $clog2(QUARTER);

	// Returns one when the APB address selects the given register.
	function automatic logic addr_hit(input logic [`WDT_ADDR_WIDTH-1:0] a,
		input logic [`WDT_ADDR_WIDTH-1:0] offset);
		addr_hit = (a == offset);
	endfunction : addr_hit

	subclock_watchdog_pkg::wdt_ctrl_type  ctrl_q;
	subclock_watchdog_pkg::wdt_ctrl_type  ctrl_d;
	subclock_watchdog_pkg::wdt_state_type state_q;
	subclock_watchdog_pkg::wdt_state_type state_d;
	logic [2:0]            sync_q;
	logic [2:0]            sync_d;
	logic                  level_q;
	logic                  level_d;
	logic [PRE_WIDTH-1:0]  pre_q;
	logic [PRE_WIDTH-1:0]  pre_d;
	logic [1:0]            stage_q;
	logic [1:0]            stage_d;
	logic [31:0]           prdata_q;
	logic [31:0]           prdata_d;
	logic                  pslverr_d;
	logic                  pslverr_q;
	logic                  access;
	logic                  wr_ctrl;
	logic                  restart;
	logic                  sub_tick;
	logic                  quarter_done;

	// Bus decode: a transfer completes in its first access cycle.
	assign access  = psel & penable;
	assign wr_ctrl = access & pwrite & addr_hit(paddr, `WDT_CTRL_OFFSET);
	assign restart = wr_ctrl & pwdata[`WDT_RESTART_POS];
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// Fixed delivery attributes of the request.
	assign nmi_level  = `WDT_NMI_LEVEL;
	assign nmi_vector = `WDT_NMI_VECTOR;

	// Sub-clock edge: counted once the second and third stages agree on high.
	always_comb
	begin
		sync_d   = {sync_q[1:0], sub_clock_oscillator};
		level_d  = level_q;
		if (sync_q[1] == sync_q[2])
		begin
			level_d = sync_q[2];
		end
		sub_tick = (sync_q[1] == sync_q[2]) & sync_q[2] & ~level_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_q  <= 3'h0;
			level_q <= 1'b0;
		end
		else
		begin
			sync_q  <= sync_d;
			level_q <= level_d;
		end
	end

	// Register writes and read data; read data and error are captured in the
	// setup cycle so that they already stand when pready is sampled high.
	always_comb
	begin
		ctrl_d    = ctrl_q;
		prdata_d  = prdata_q;
		pslverr_d = pslverr_q;
		if (wr_ctrl)
		begin
			ctrl_d.enable = pwdata[`WDT_ENABLE_POS];
		end
		if (psel & ~penable)
		begin
			pslverr_d = 1'b0;
			prdata_d = 32'h0;
			if (addr_hit(paddr, `WDT_CTRL_OFFSET))
			begin
				prdata_d[`WDT_ENABLE_POS] = ctrl_q.enable;
				prdata_d[`WDT_RESTART_POS] = 1'b0;
			end
			else if (addr_hit(paddr, `WDT_STATUS_OFFSET))
			begin
				prdata_d[`WDT_STAT_PENDING_POS] = nmi_request;
				prdata_d[`WDT_STAT_STAGE_LSB +: 2] = stage_q;
			end
			else
			begin
				pslverr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q.enable <= `WDT_ENABLE_RESET;
			prdata_q      <= 32'h0;
			pslverr_q     <= 1'b0;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Quarter prescaler, held while stopped or asleep; restart clears only the quarter stage,
	// so the timeout lands between three and four quarters of the period.
	assign quarter_done = sub_tick & (pre_q == PRE_WIDTH'(QUARTER - 1));

	always_comb
	begin
		pre_d   = pre_q;
		stage_d = stage_q;
		state_d = state_q;
		case (state_q)
			subclock_watchdog_pkg::ST_STOPPED:
			begin
				if (ctrl_q.enable)
				begin
					state_d = subclock_watchdog_pkg::ST_COUNTING;
				end
			end
			subclock_watchdog_pkg::ST_COUNTING:
			begin
				// Sleep freezes prescaler and stage; halt has no input and never stops us.
				if (sub_tick & ~sleep_active)
				begin
					pre_d = quarter_done ? '0 : pre_q + 1'b1;
					if (quarter_done)
					begin
						stage_d = stage_q + 2'h1;
						if (stage_q == `WDT_STAGE_LAST)
						begin
							state_d = subclock_watchdog_pkg::ST_EXPIRED;
						end
					end
				end
			end
			subclock_watchdog_pkg::ST_EXPIRED:
			begin
				state_d = subclock_watchdog_pkg::ST_EXPIRED;
			end
			default:
			begin
				state_d = subclock_watchdog_pkg::ST_STOPPED;
			end
		endcase
		// Same-clock control: restart and disable act in the write cycle itself.
		if (restart)
		begin
			stage_d = 2'h0;
			if (ctrl_d.enable)
			begin
				state_d = subclock_watchdog_pkg::ST_COUNTING;
			end
		end
		if (!ctrl_d.enable)
		begin
			state_d = subclock_watchdog_pkg::ST_STOPPED;
			stage_d = 2'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= subclock_watchdog_pkg::ST_COUNTING;
			pre_q   <= '0;
			stage_q <= 2'h0;
		end
		else
		begin
			state_q <= state_d;
			pre_q   <= pre_d;
			stage_q <= stage_d;
		end
	end

	// Request is a level held until restart or disable.
	assign nmi_request = (state_q == subclock_watchdog_pkg::ST_EXPIRED);

endmodule : subclock_watchdog_timer

// ### test/subclock_watchdog_timer_assertions.sv
// Purpose: Port checks of the watchdog timer.
// Assumes: Sub-clock period of 8 pclk cycles, quarter of 4 sub-clocks.
// Notes:   Bound to the timer.
`timescale 1ns/1ps
`include "subclock_watchdog_cfg.svh"
module subclock_watchdog_timer_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        sleep_active,
	input wire logic        nmi_request,
	input wire logic [2:0]  nmi_level,
	input wire logic [23:0] nmi_vector
);
	// Completing access to the control word.
	wire ctrl_acc = psel & penable & (paddr == `WDT_CTRL_OFFSET);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Shortest timeout leaves the request low this long.
	sequence quiet_window;
		!nmi_request throughout (##80 1'b1);
	endsequence
	a_level_four: assert property (nmi_level == `WDT_NMI_LEVEL)
		else $error("request level wrong");
	a_vector_fixed: assert property (nmi_vector == `WDT_NMI_VECTOR)
		else $error("vector wrong");
	a_off_quiet: assert property (ctrl_acc && pwrite && !pwdata[7] |=> !nmi_request [*8])
		else $error("request while disabled");
	a_restart_clears: assert property (ctrl_acc && pwrite && pwdata[2] |=> !nmi_request)
		else $error("restart left request");
	a_restart_reads: assert property (ctrl_acc && !pwrite |=> !prdata[2] && !(|prdata[31:8]))
		else $error("restart bit read back");
	a_sleep_frozen: assert property ((sleep_active && !nmi_request) [*3] |=> !nmi_request)
		else $error("request in sleep");
	a_request_holds: assert property ($fell(nmi_request) |-> $past(ctrl_acc && pwrite))
		else $error("request dropped alone");
	a_early_none: assert property (ctrl_acc && pwrite && pwdata[2] && pwdata[7] |=> quiet_window)
		else $error("timeout too early");
endmodule : subclock_watchdog_timer_assertions
bind subclock_watchdog_timer subclock_watchdog_timer_assertions u_chk (.*);

// ### test/core_nmi_partner.sv
// Purpose: Sub-clock source and core request counter.
// Assumes: Sub-clock runs free at 25 MHz, phase unrelated to pclk.
// Notes:   Each rising request counts as one exception taken.
`timescale 1ns/1ps
module core_nmi_partner (
	output logic      sub_clock_oscillator,
	input  wire logic nmi_request,
	output int        nmi_count
);
	// Free-running sub-clock, shortened for simulation.
	initial
	begin
		sub_clock_oscillator = 1'b0;
		#7.3;
		forever #20 sub_clock_oscillator = ~sub_clock_oscillator;
	end
	// Request edges taken by the core.
	initial
	begin
		nmi_count = 0;
		forever @(posedge nmi_request) nmi_count++;
	end
endmodule : core_nmi_partner

// ### test/tb_subclock_watchdog_timer.sv
// Purpose: Self-checking bench of the watchdog timer.
// Assumes: Period 16 sub-clocks, sub-clock of 8 pclk cycles.
// Notes:   Read data and error are taken at the edge where pready is sampled high.
`timescale 1ns/1ps
`include "subclock_watchdog_cfg.svh"
module tb_subclock_watchdog_timer;
	logic        pclk, presetn, psel, penable, pwrite, sleep_active;
	logic        pready, pslverr, er, nmi_request, sub_clock_oscillator;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  nmi_level;
	logic [23:0] nmi_vector;
	int          error_cnt, tests_run, exp_en, exp_nmi, nmi_count, cyc, i;
	subclock_watchdog_timer #(.PERIOD_CYCLES(16)) uut (.*);
	core_nmi_partner far (.*);
	// Clock.
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, held until pready.
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20)
			error_cnt++;
		if (n >= 20)
			tally_and_finish;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		#1;
	endtask : apb
	// Counts cycles until the request shows, at most lim.
	task wait_nmi(input int lim);
		cyc = 0;
		while (nmi_request !== 1'b1 && cyc < lim)
		begin
			@(posedge pclk);
			#1;
			cyc++;
		end
	endtask : wait_nmi
	// Main sequence.
	initial
	begin
		{presetn, psel, penable, pwrite, sleep_active, paddr, pwdata} = '0;
		error_cnt = 0;
		tests_run = 0;
		exp_en = 1;
		exp_nmi = 0;
		void'($urandom(6187));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `WDT_CTRL_OFFSET, 32'h0);
		chk(rd, exp_en << 7);
		apb(1'b1, `WDT_CTRL_OFFSET, 32'h84);
		sleep_active <= 1'b1;
		wait_nmi(300);
		chk(cyc, 300);
		sleep_active <= 1'b0;
		wait_nmi(200);
		chk(nmi_request, 1'b1);
		exp_nmi++;
		apb(1'b0, `WDT_STATUS_OFFSET, 32'h0);
		chk(rd[0], 1'b1);
		for (i = 0; i < 4; i++)
		begin
			repeat ($urandom_range(1, 40)) @(posedge pclk);
			apb(1'b1, `WDT_CTRL_OFFSET, ($urandom & 32'h7b) | 32'h84);
			chk(nmi_request, 1'b0);
			wait_nmi(200);
			chk(cyc >= 85 && cyc <= 140, 1'b1);
			exp_nmi++;
		end
		apb(1'b0, `WDT_CTRL_OFFSET, 32'h0);
		chk(rd, exp_en << 7);
		apb(1'b1, `WDT_CTRL_OFFSET, 32'h04);
		exp_en = 0;
		wait_nmi(300);
		chk(cyc, 300);
		apb(1'b0, `WDT_CTRL_OFFSET, 32'h0);
		chk(rd, exp_en << 7);
		apb(1'b1, `WDT_CTRL_OFFSET, 32'h80);
		wait_nmi(200);
		chk(nmi_request, 1'b1);
		exp_nmi++;
		apb(1'b1, 16'hff48, 32'hff);
		chk({er, rd}, {1'b1, 32'h0});
		chk(nmi_count, exp_nmi);
		chk(nmi_level, 3'h4);
		chk(nmi_vector, 24'h000004);
		tally_and_finish;
	end
endmodule : tb_subclock_watchdog_timer
